// ---- src/dtc_pkg.sv ----
package dtc_pkg;

	// Register offsets on the byte register port
	localparam logic [7:0] ADDR_CTRL_FLAGS = 8'h88;
	localparam logic [7:0] ADDR_MODE_SEL = 8'h89;
	localparam logic [7:0] ADDR_T0_LOW = 8'h8a;
	localparam logic [7:0] ADDR_T1_LOW = 8'h8b;
	localparam logic [7:0] ADDR_T0_HIGH = 8'h8c;
	localparam logic [7:0] ADDR_T1_HIGH = 8'h8d;
	localparam logic [7:0] ADDR_CLK_MODE = 8'h8e;

	// Bit positions in timer_control_flags
	localparam int BIT_TF1 = 7;
	localparam int BIT_TR1 = 6;
	localparam int BIT_TF0 = 5;
	localparam int BIT_TR0 = 4;
	localparam int BIT_IE1 = 3;
	localparam int BIT_IT1 = 2;
	localparam int BIT_IE0 = 1;
	localparam int BIT_IT0 = 0;

	// Bit positions in the clock mode register
	localparam int BIT_T1M = 4;
	localparam int BIT_T0M = 3;

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;

	// Prescaler: internal source is system clock divided by this
	localparam int PRESCALE_DIV = 12;
	localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE_DIV - 1);

	typedef enum logic [1:0] {
		MODE_13BIT,
		MODE_16BIT,
		MODE_8BIT_RELOAD,
		MODE_SPLIT
	} dtc_mode_t;

	// One nibble of timer_mode_select
	typedef struct packed {
		logic gate;
		logic count_sel;
		dtc_mode_t mode;
	} dtc_tmode_t;

	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} dtc_req_t;

endpackage

// ---- src/dtc_timer.sv ----
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps

// Functional notes
// - Timer one overflow sets its flag; service entry clears; software writes either value.
// - Timer zero overflow sets its flag; service entry clears; software writes either value.
// - Timer one runs while run bit set; clearing freezes both count bytes.
// - Timer zero runs while run bit set; clearing freezes both count bytes outside mode 11, where the high byte runs on timer one's run bit.
// - Interrupt one edge mode: falling edge sets flag, held until software or service clears.
// - Interrupt one level mode: flag equals inverted pin, software writes ignored.
// - Interrupt zero edge mode: falling edge sets flag, held until cleared.
// - Interrupt zero level mode: flag tracks inverted pin, read-only to software.
// - Timer one gate set: counts only while run set and interrupt one pin high.
// - Timer zero gate set: counts only while run set and interrupt zero pin high.
// - Timer one select: internal clock when 0, count pin falling edges when 1.
// - Timer zero select: internal clock when 0, count pin falling edges when 1.
// - Timer one modes: 13-bit, 16-bit, 8-bit auto-reload from high byte.
// - Timer one mode 11 halts it regardless of run bit.
// - Timer zero modes: 13-bit, 16-bit, 8-bit auto-reload, same encoding.
// - Timer zero mode 11: low byte and high byte run as separate 8-bit timers.
// - Timer zero count is 16 bits, low and high byte registers read/write.
// - Timer one count is 16 bits, low and high byte registers read/write.
// - Reset clears control, mode and all four count bytes.
// - Internal source is system clock divided by 12, or undivided when clock mode set.
module dtc_timer
	import dtc_pkg::*;
(
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	// Register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	// Interrupt service entry strobes from the core
	input wire logic T0_SVC_ACK,
	input wire logic T1_SVC_ACK,
	input wire logic EXT_INT_ZERO_PIN_SVC_ACK,
	input wire logic EXT_INT_ONE_PIN_SVC_ACK,
	// External pins
	input wire logic EXT_INT_ZERO_PIN_N,
	input wire logic EXT_INT_ONE_PIN_N,
	input wire logic COUNT_INPUT_ZERO_PIN,
	input wire logic COUNT_INPUT_ONE_PIN,
	// Flags toward the interrupt controller
	output logic T0_OVF_FLAG,
	output logic T1_OVF_FLAG,
	output logic EXT_INT_ZERO_PIN_FLAG,
	output logic EXT_INT_ONE_PIN_FLAG
);

	dtc_req_t req;
	logic tf1_q, tr1_q, tf0_q, tr0_q, ie1_q, it1_q, ie0_q, it0_q;
	logic [7:0] timer_mode_select_q;
	logic t1m_q, t0m_q;
	logic [7:0] tl0_q, th0_q, tl1_q, th1_q;
	logic [7:0] tl0_d, th0_d, tl1_d, th1_d;
	logic [3:0] pre_q;
	logic ext_int_zero_pin_prev_q, ext_int_one_pin_prev_q, cnt0_prev_q, cnt1_prev_q;
	logic tick12, tick0_int, tick1_int, tick0_src, tick1_src;
	logic en0, en1, en0_high;
	logic ovf0, ovf1;
	logic wr_tl0, wr_th0, wr_tl1, wr_th1, wr_ctrl;
	logic ext_int_zero_pin_fall, ext_int_one_pin_fall;
	dtc_tmode_t m0, m1;

	assign req = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};
	assign m0 = dtc_tmode_t'(timer_mode_select_q[3:0]);
	assign m1 = dtc_tmode_t'(timer_mode_select_q[7:4]);

	assign wr_ctrl = req.wr && req.addr == ADDR_CTRL_FLAGS;
	assign wr_tl0 = req.wr && req.addr == ADDR_T0_LOW;
	assign wr_th0 = req.wr && req.addr == ADDR_T0_HIGH;
	assign wr_tl1 = req.wr && req.addr == ADDR_T1_LOW;
	assign wr_th1 = req.wr && req.addr == ADDR_T1_HIGH;

	////////////////////////////////////////////////////////////////////////////////
	// Clock source and edge detection

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			pre_q <= 4'h0;
		end else if (pre_q == PRESCALE_LAST) begin
			pre_q <= 4'h0;
		end else begin
			pre_q <= pre_q + 4'h1;
		end
	end

	assign tick12 = pre_q == PRESCALE_LAST;
	assign tick0_int = t0m_q ? 1'b1 : tick12;
	assign tick1_int = t1m_q ? 1'b1 : tick12;

	// Pins are taken as synchronous; only one stage for edge history
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			ext_int_zero_pin_prev_q <= 1'b1;
			ext_int_one_pin_prev_q <= 1'b1;
			cnt0_prev_q <= 1'b1;
			cnt1_prev_q <= 1'b1;
		end else begin
			ext_int_zero_pin_prev_q <= EXT_INT_ZERO_PIN_N;
			ext_int_one_pin_prev_q <= EXT_INT_ONE_PIN_N;
			cnt0_prev_q <= COUNT_INPUT_ZERO_PIN;
			cnt1_prev_q <= COUNT_INPUT_ONE_PIN;
		end
	end

	assign ext_int_zero_pin_fall = ext_int_zero_pin_prev_q && !EXT_INT_ZERO_PIN_N;
	assign ext_int_one_pin_fall = ext_int_one_pin_prev_q && !EXT_INT_ONE_PIN_N;
	assign tick0_src = m0.count_sel ? (cnt0_prev_q && !COUNT_INPUT_ZERO_PIN) : tick0_int;
	assign tick1_src = m1.count_sel ? (cnt1_prev_q && !COUNT_INPUT_ONE_PIN) : tick1_int;

	// Gate lets the interrupt pin level qualify the run bit
	assign en0 = tr0_q && (!m0.gate || EXT_INT_ZERO_PIN_N) && tick0_src;
	assign en1 = tr1_q && (!m1.gate || EXT_INT_ONE_PIN_N) && tick1_src
		&& m1.mode != MODE_SPLIT;
	// Split-mode high byte counts the internal clock under timer one run
	assign en0_high = tr1_q && tick0_int;

	////////////////////////////////////////////////////////////////////////////////
	// Counter next-state

	always_comb begin
		tl0_d = tl0_q;
		th0_d = th0_q;
		ovf0 = 1'b0;
		ovf1 = 1'b0;
		case (m0.mode)
			MODE_13BIT: begin
				if (en0) begin
					if (tl0_q[4:0] == 5'h1f) begin
						th0_d = th0_q + 8'h01;
						ovf0 = th0_q == 8'hff;
					end
					tl0_d = {tl0_q[7:5], tl0_q[4:0] + 5'h01};
				end
			end
			MODE_16BIT: begin
				if (en0) begin
					tl0_d = tl0_q + 8'h01;
					if (tl0_q == 8'hff) begin
						th0_d = th0_q + 8'h01;
						ovf0 = th0_q == 8'hff;
					end
				end
			end
			MODE_8BIT_RELOAD: begin
				if (en0) begin
					tl0_d = (tl0_q == 8'hff) ? th0_q : tl0_q + 8'h01;
					ovf0 = tl0_q == 8'hff;
				end
			end
			default: begin
				if (en0) begin
					tl0_d = tl0_q + 8'h01;
					ovf0 = tl0_q == 8'hff;
				end
				if (en0_high) begin
					th0_d = th0_q + 8'h01;
					ovf1 = th0_q == 8'hff;
				end
			end
		endcase
	end

	always_comb begin
		tl1_d = tl1_q;
		th1_d = th1_q;
		if (en1) begin
			case (m1.mode)
				MODE_13BIT: begin
					if (tl1_q[4:0] == 5'h1f) begin
						th1_d = th1_q + 8'h01;
					end
					tl1_d = {tl1_q[7:5], tl1_q[4:0] + 5'h01};
				end
				MODE_16BIT: begin
					tl1_d = tl1_q + 8'h01;
					if (tl1_q == 8'hff) begin
						th1_d = th1_q + 8'h01;
					end
				end
				default: begin
					tl1_d = (tl1_q == 8'hff) ? th1_q : tl1_q + 8'h01;
				end
			endcase
		end
	end

	// Timer one overflow unless it is held by mode 11
	logic t1_wrap;
	always_comb begin
		t1_wrap = 1'b0;
		if (en1) begin
			case (m1.mode)
				MODE_13BIT: t1_wrap = tl1_q[4:0] == 5'h1f && th1_q == 8'hff;
				MODE_16BIT: t1_wrap = tl1_q == 8'hff && th1_q == 8'hff;
				default: t1_wrap = tl1_q == 8'hff;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Count registers; a software write wins over counting in the same cycle

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			tl0_q <= RST_BYTE;
			th0_q <= RST_BYTE;
			tl1_q <= RST_BYTE;
			th1_q <= RST_BYTE;
		end else begin
			tl0_q <= wr_tl0 ? req.wdata : tl0_d;
			th0_q <= wr_th0 ? req.wdata : th0_d;
			tl1_q <= wr_tl1 ? req.wdata : tl1_d;
			th1_q <= wr_th1 ? req.wdata : th1_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode and clock mode registers

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			timer_mode_select_q <= RST_BYTE;
			t1m_q <= 1'b0;
			t0m_q <= 1'b0;
		end else begin
			if (req.wr && req.addr == ADDR_MODE_SEL) begin
				timer_mode_select_q <= req.wdata;
			end
			if (req.wr && req.addr == ADDR_CLK_MODE) begin
				t1m_q <= req.wdata[BIT_T1M];
				t0m_q <= req.wdata[BIT_T0M];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control flags: hardware set wins over any clear in the same cycle

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			tf1_q <= 1'b0;
			tr1_q <= 1'b0;
			tf0_q <= 1'b0;
			tr0_q <= 1'b0;
			it1_q <= 1'b0;
			it0_q <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				tr1_q <= req.wdata[BIT_TR1];
				tr0_q <= req.wdata[BIT_TR0];
				it1_q <= req.wdata[BIT_IT1];
				it0_q <= req.wdata[BIT_IT0];
			end
			if (t1_wrap || ovf1) begin
				tf1_q <= 1'b1;
			end else if (wr_ctrl) begin
				tf1_q <= req.wdata[BIT_TF1];
			end else if (T1_SVC_ACK) begin
				tf1_q <= 1'b0;
			end
			if (ovf0) begin
				tf0_q <= 1'b1;
			end else if (wr_ctrl) begin
				tf0_q <= req.wdata[BIT_TF0];
			end else if (T0_SVC_ACK) begin
				tf0_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			ie1_q <= 1'b0;
			ie0_q <= 1'b0;
		end else begin
			if (!it1_q) begin
				ie1_q <= !EXT_INT_ONE_PIN_N;
			end else if (ext_int_one_pin_fall) begin
				ie1_q <= 1'b1;
			end else if (wr_ctrl) begin
				ie1_q <= req.wdata[BIT_IE1];
			end else if (EXT_INT_ONE_PIN_SVC_ACK) begin
				ie1_q <= 1'b0;
			end
			if (!it0_q) begin
				ie0_q <= !EXT_INT_ZERO_PIN_N;
			end else if (ext_int_zero_pin_fall) begin
				ie0_q <= 1'b1;
			end else if (wr_ctrl) begin
				ie0_q <= req.wdata[BIT_IE0];
			end else if (EXT_INT_ZERO_PIN_SVC_ACK) begin
				ie0_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read port and flag outputs

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			REG_RDATA <= 8'h00;
		end else if (!req.rd) begin
			REG_RDATA <= 8'h00;
		end else if (req.addr == ADDR_CTRL_FLAGS) begin
			REG_RDATA <= {tf1_q, tr1_q, tf0_q, tr0_q, ie1_q, it1_q, ie0_q, it0_q};
		end else if (req.addr == ADDR_MODE_SEL) begin
			REG_RDATA <= timer_mode_select_q;
		end else if (req.addr == ADDR_T0_LOW) begin
			REG_RDATA <= tl0_q;
		end else if (req.addr == ADDR_T1_LOW) begin
			REG_RDATA <= tl1_q;
		end else if (req.addr == ADDR_T0_HIGH) begin
			REG_RDATA <= th0_q;
		end else if (req.addr == ADDR_T1_HIGH) begin
			REG_RDATA <= th1_q;
		end else if (req.addr == ADDR_CLK_MODE) begin
			REG_RDATA <= {3'h0, t1m_q, t0m_q, 3'h0};
		end else begin
			REG_RDATA <= 8'h00;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			T0_OVF_FLAG <= 1'b0;
			T1_OVF_FLAG <= 1'b0;
			EXT_INT_ZERO_PIN_FLAG <= 1'b0;
			EXT_INT_ONE_PIN_FLAG <= 1'b0;
		end else begin
			T0_OVF_FLAG <= tf0_q;
			T1_OVF_FLAG <= tf1_q;
			EXT_INT_ZERO_PIN_FLAG <= ie0_q;
			EXT_INT_ONE_PIN_FLAG <= ie1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	stopped_t1_holds_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(!tr1_q && !wr_tl1 && !wr_th1 && !(m0.mode == MODE_SPLIT))
		|=> (tl1_q == $past(tl1_q) && th1_q == $past(th1_q)))
		else $error("timer one count moved while stopped");
	stopped_t0_holds_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(!tr0_q && !wr_tl0 && !wr_th0 && m0.mode != MODE_SPLIT)
		|=> (tl0_q == $past(tl0_q) && th0_q == $past(th0_q)))
		else $error("timer zero count moved while stopped");
	t1_halt_mode_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(m1.mode == MODE_SPLIT && !wr_tl1) |=> tl1_q == $past(tl1_q))
		else $error("timer one counted in mode 11");
	tf0_set_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		ovf0 |=> tf0_q)
		else $error("timer zero overflow not flagged");
	tf1_set_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		t1_wrap |=> tf1_q)
		else $error("timer one overflow not flagged");
	ext_int_one_pin_level_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		$past(!it1_q) |-> ie1_q == !$past(EXT_INT_ONE_PIN_N))
		else $error("interrupt one level flag wrong");
	ext_int_zero_pin_level_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		$past(!it0_q) |-> ie0_q == !$past(EXT_INT_ZERO_PIN_N))
		else $error("interrupt zero level flag wrong");
	ext_int_zero_pin_edge_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(it0_q && ext_int_zero_pin_fall) |=> ie0_q ##1 EXT_INT_ZERO_PIN_FLAG)
		else $error("interrupt zero edge not caught");
	ext_int_one_pin_edge_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(it1_q && ext_int_one_pin_fall) |=> ie1_q)
		else $error("interrupt one edge not caught");
	reload_t0_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(m0.mode == MODE_8BIT_RELOAD && en0 && tl0_q == 8'hff && !wr_tl0)
		|=> tl0_q == $past(th0_q))
		else $error("timer zero reload missed");
	gate_t0_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(m0.gate && !EXT_INT_ZERO_PIN_N) |-> !en0)
		else $error("timer zero counted with gate closed");
	prescale_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		tick12 |=> !tick12 [*8])
		else $error("prescaler period too short");

endmodule

// ---- test/dtc_pins_model.sv ----
`timescale 1ns/1ps

// Core service strobes and external pins, all changed just after a clock edge
module dtc_pins_model (
	// Clock
	input wire logic clk,
	// Pins and service strobes
	output logic [1:0] int_n,
	output logic [1:0] cnt,
	output logic [3:0] ack
);
	initial begin
		int_n = 2'h3;
		cnt = 2'h3;
		ack = 4'h0;
	end

	task automatic set_int(input int i, input logic v);
		@(posedge clk);
		int_n[i] <= v;
	endtask

	// Count pins rest high, so only deliberate pulses make falling edges
	task automatic pulse(input int i, input int n);
		repeat (n) begin
			@(posedge clk);
			cnt[i] <= 1'b0;
			@(posedge clk);
			cnt[i] <= 1'b1;
		end
	endtask

	task automatic svc(input int i);
		@(posedge clk);
		ack[i] <= 1'b1;
		@(posedge clk);
		ack[i] <= 1'b0;
	endtask
endmodule

// ---- test/dual_timer_counter_ext_int_tb_top.sv ----
`timescale 1ns/1ps

module dual_timer_counter_ext_int_tb_top;
	import dtc_pkg::*;

	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [7:0] ie;
	logic [7:0] it;
	wire [7:0] rdata;
	wire [1:0] int_n;
	wire [1:0] cnt;
	wire [3:0] ack;
	wire [3:0] flag;
	int error_cnt = 0;
	int n_checks = 0;

	always #2.5 clk_sys = ~clk_sys;

	dtc_pins_model pm (.clk(clk_sys), .int_n(int_n), .cnt(cnt), .ack(ack));

	dtc_timer uut (
		.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata),
		.T0_SVC_ACK(ack[0]), .T1_SVC_ACK(ack[1]), .EXT_INT_ZERO_PIN_SVC_ACK(ack[2]), .EXT_INT_ONE_PIN_SVC_ACK(ack[3]),
		.EXT_INT_ZERO_PIN_N(int_n[0]), .EXT_INT_ONE_PIN_N(int_n[1]),
		.COUNT_INPUT_ZERO_PIN(cnt[0]), .COUNT_INPUT_ONE_PIN(cnt[1]),
		.T0_OVF_FLAG(flag[0]), .T1_OVF_FLAG(flag[1]), .EXT_INT_ZERO_PIN_FLAG(flag[2]), .EXT_INT_ONE_PIN_FLAG(flag[3])
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t byte %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t flag %b expected %b", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk_sys);
		wr_s <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk_sys);
		rd_s <= 1'b0;
		#1;
		chk8(rdata, exp);
	endtask

	// Timer counts on n+2 edges: the start write edge excluded, the stop edge included
	task automatic run(input logic [7:0] go, input int n, input logic [7:0] stop);
		wr(ADDR_CTRL_FLAGS, go);
		repeat (n) @(posedge clk_sys);
		wr(ADDR_CTRL_FLAGS, stop);
		#1;
	endtask

	task automatic cnt_case(input int i, input logic [3:0] m, input logic g, input int p,
		input logic [7:0] e);
		logic [7:0] lo;
		lo = i ? ADDR_T1_LOW : ADDR_T0_LOW;
		wr(ADDR_MODE_SEL, i ? {m, 4'h0} : {4'h0, m});
		wr(lo, 8'h00);
		pm.set_int(i, g);
		wr(ADDR_CTRL_FLAGS, i ? 8'h40 : 8'h10);
		if (p > 0) pm.pulse(i, p);
		else repeat (8) @(posedge clk_sys);
		wr(ADDR_CTRL_FLAGS, 8'h00);
		pm.set_int(i, 1'b1);
		rd(lo, e);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		for (int i = 0; i < 7; i++) rd(ADDR_CTRL_FLAGS + 8'(i), RST_BYTE);
		wr(8'h8f, 8'hff);
		rd(8'h8f, 8'h00);
		for (int i = 2; i < 6; i++) begin
			wr(ADDR_CTRL_FLAGS + 8'(i), 8'h3c ^ 8'(i));
			rd(ADDR_CTRL_FLAGS + 8'(i), 8'h3c ^ 8'(i));
		end
		// Divided source: any 120 edges hold exactly ten prescaler ticks
		wr(ADDR_MODE_SEL, 8'h01);
		wr(ADDR_T0_LOW, 8'h00);
		wr(ADDR_T0_HIGH, 8'h00);
		run(8'h10, 118, 8'h00);
		rd(ADDR_T0_LOW, 8'h0a);
		wr(ADDR_CLK_MODE, 8'h18);
		rd(ADDR_CLK_MODE, 8'h18);
		wr(ADDR_MODE_SEL, 8'h11);
		wr(ADDR_T0_HIGH, 8'hff);
		wr(ADDR_T0_LOW, 8'hf0);
		// Stop write leaves the flag bit at 0, so only the wrap can set it
		run(8'h10, 18, 8'h00);
		chk1(flag[0], 1'b1);
		rd(ADDR_T0_LOW, 8'h04);
		rd(ADDR_T0_HIGH, 8'h00);
		pm.svc(0);
		rd(ADDR_CTRL_FLAGS, 8'h00);
		wr(ADDR_MODE_SEL, 8'h20);
		wr(ADDR_T1_HIGH, 8'hf0);
		wr(ADDR_T1_LOW, 8'hfe);
		run(8'h40, 3, 8'h00);
		chk1(flag[1], 1'b1);
		rd(ADDR_T1_LOW, 8'hf3);
		pm.svc(1);
		rd(ADDR_CTRL_FLAGS, 8'h00);
		wr(ADDR_CTRL_FLAGS, 8'h80);
		rd(ADDR_CTRL_FLAGS, 8'h80);
		wr(ADDR_MODE_SEL, 8'h00);
		wr(ADDR_T0_HIGH, 8'h00);
		wr(ADDR_T0_LOW, 8'hfe);
		run(8'h10, 1, 8'h00);
		rd(ADDR_T0_LOW, 8'he1);
		rd(ADDR_T0_HIGH, 8'h01);
		wr(ADDR_MODE_SEL, 8'h03);
		wr(ADDR_T0_HIGH, 8'hfe);
		wr(ADDR_T0_LOW, 8'h00);
		run(8'h40, 8, 8'h00);
		chk1(flag[1], 1'b1);
		rd(ADDR_T0_HIGH, 8'h08);
		rd(ADDR_T0_LOW, 8'h00);
		cnt_case(0, 4'h9, 1'b0, 0, 8'h00);
		cnt_case(0, 4'h9, 1'b1, 0, 8'h0a);
		cnt_case(1, 4'h9, 1'b0, 0, 8'h00);
		cnt_case(1, 4'h1, 1'b0, 0, 8'h0a);
		cnt_case(0, 4'h5, 1'b1, 3, 8'h03);
		cnt_case(1, 4'h5, 1'b1, 3, 8'h03);
		cnt_case(1, 4'h3, 1'b1, 0, 8'h00);
		for (int i = 0; i < 2; i++) begin
			ie = 8'h02 << (2 * i);
			it = 8'h01 << (2 * i);
			pm.set_int(i, 1'b0);
			wr(ADDR_CTRL_FLAGS, 8'h00);
			rd(ADDR_CTRL_FLAGS, ie);
			pm.set_int(i, 1'b1);
			rd(ADDR_CTRL_FLAGS, 8'h00);
			wr(ADDR_CTRL_FLAGS, it);
			pm.set_int(i, 1'b0);
			pm.set_int(i, 1'b1);
			rd(ADDR_CTRL_FLAGS, it | ie);
			chk1(flag[2 + i], 1'b1);
			pm.svc(2 + i);
			rd(ADDR_CTRL_FLAGS, it);
			wr(ADDR_CTRL_FLAGS, it | ie);
			rd(ADDR_CTRL_FLAGS, it | ie);
			wr(ADDR_CTRL_FLAGS, 8'h00);
		end
		test_done();
	end

	// The whole sequence needs well under 2000 cycles
	initial begin
		#30us;
		error_cnt++;
		test_done();
	end
endmodule
